// ### hdl/ppoc_pkg.sv
package ppoc_pkg;
    // register byte addresses
    localparam logic [5:0] ADDR_OPT_A = 6'h00;
    localparam logic [5:0] ADDR_POL_SYNC = 6'h04;
    localparam logic [5:0] ADDR_SYNC_DLY = 6'h08;
    localparam logic [5:0] ADDR_PANEL_TYPE = 6'h0c;
    localparam logic [5:0] ADDR_CFG = 6'h10;
    localparam logic [5:0] ADDR_STATUS = 6'h14;
    // panel_option_reg_a fields
    localparam int OPT_A_REV_EN = 4;
    localparam int OPT_A_DAC_OFF = 7;
    // panel_polarity_sync_options fields
    localparam int POL_TEXT_ONLY = 3;
    localparam int POL_SYNC_STEER = 2;
    localparam int POL_FRAME_INV = 1;
    localparam int POL_LINE_INV = 0;
    // sync_delay_reg fields
    localparam int DLY_MSB = 7;
    localparam int DLY_B1 = 1;
    localparam int DLY_B0 = 0;
    // panel_type_reg fields
    localparam int PT_TFT_EN = 3;
    // own configuration register fields
    localparam int CFG_PANEL_EN = 0;
    localparam int CFG_CRT_EN = 1;
    localparam int CFG_PWRDN = 2;
    localparam int CFG_DITHER = 3;
    localparam int CFG_STN_COLOR = 4;
    localparam int CFG_VEXP = 5;
    localparam int CFG_CENTER = 6;
    // misc output register sync polarity bits
    localparam int MISC_VSYNC_POL = 7;
    localparam int MISC_HSYNC_POL = 6;
    // reset values
    localparam logic [7:0] RST_OPT_A = 8'h00;
    localparam logic [7:0] RST_POL_SYNC = 8'h00;
    localparam logic [7:0] RST_SYNC_DLY = 8'h00;
    localparam logic [7:0] RST_PANEL_TYPE = 8'h00;
    localparam logic [7:0] RST_CFG = 8'h01;
    // hsync delay line length
    localparam int HS_DLY_MAX = 7;
    localparam int STN_COLORS_BASE = 512;
    localparam int STN_COLORS_ENH = 4096;
endpackage : ppoc_pkg

// ### hdl/ppoc_panel_output_option_control.sv
// Notes on behaviour
// - with reverse video disabled, both text and graphics show normal video.
// - with reverse video enabled and text-only clear, both modes show reverse video.
// - with reverse video enabled and text-only set, text is reversed and graphics normal.
// - panel select output is high for crt only, low for panel only and simultaneous.
// - sync steering clear: direction pins carry the buffer direction signals.
// - sync steering set: low pin carries crt vsync, high pin carries crt hsync.
// - with a tft panel enabled crt syncs pulse low regardless of misc polarity bits.
// - frame pulse is inverted when its polarity bit is 1, normal when 0.
// - line pulse is inverted when its polarity bit is 1, normal when 0.
// - horizontal sync is delayed by 0 to 7 clocks given by bits 7, 1, 0.
// - the dither clock is gated off when dithering is not needed.
// - panel data outputs are forced low in reset and powerdown.
// - stn colour panels get 4k colours instead of 512.
// - crt and single colour panel may run together with expansion and centering.
`timescale 1ns/10ps
`default_nettype none
module ppoc_panel_output_option_control (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic attr_graphics_mode,
    input wire logic [7:0] misc_output,
    input wire logic crt_vsync_raw,
    input wire logic crt_hsync_raw,
    input wire logic low_byte_dir_int,
    input wire logic high_byte_dir_int,
    input wire logic frame_pulse_int,
    input wire logic line_pulse_int,
    input wire logic [3:0] upper_panel_data_int,
    input wire logic [3:0] lower_panel_data_int,
    input wire logic pix_invert_src,
    output logic low_byte_dir,
    output logic high_byte_dir,
    output logic crt_vsync,
    output logic crt_hsync,
    output logic frame_pulse,
    output logic line_pulse,
    output logic [3:0] upper_panel_data,
    output logic [3:0] lower_panel_data,
    output logic panel_select_out,
    output logic dither_clk_en,
    output logic dac_off,
    output logic color_depth_4k,
    output logic simul_expand_center
);

////////////////////////////////////////////////////////////////////////////////
typedef struct packed {
    logic [7:0] opt_a;
    logic [7:0] pol_sync;
    logic [7:0] sync_dly;
    logic [7:0] panel_type;
    logic [7:0] cfg;
    logic [31:0] rdata;
    logic ack;
    logic [7:0] hs_line;
    logic lbd;
    logic hbd;
    logic vs;
    logic hs;
    logic fp;
    logic lp;
    logic [3:0] ud;
    logic [3:0] ld;
    logic psel;
    logic dith;
    logic dac;
    logic c4k;
    logic sim;
} ppoc_state_t;

ppoc_state_t st_q;
ppoc_state_t st_d;

function automatic logic [7:0] ppoc_merge(input logic [7:0] old, input logic [31:0] wd,
                                          input logic sel0);
    ppoc_merge = sel0 ? wd[7:0] : old;
endfunction : ppoc_merge

logic wb_req;
logic [2:0] hs_delay;
logic reverse_on;
logic hs_delayed;
logic crt_only;
logic sim_mode;
logic tft_on;

assign wb_req = wb_cyc_i && wb_stb_i && !st_q.ack;
assign hs_delay = {st_q.sync_dly[ppoc_pkg::DLY_MSB], st_q.sync_dly[ppoc_pkg::DLY_B1],
                   st_q.sync_dly[ppoc_pkg::DLY_B0]};
assign tft_on = st_q.panel_type[ppoc_pkg::PT_TFT_EN];
assign crt_only = st_q.cfg[ppoc_pkg::CFG_CRT_EN] && !st_q.cfg[ppoc_pkg::CFG_PANEL_EN];
assign sim_mode = st_q.cfg[ppoc_pkg::CFG_CRT_EN] && st_q.cfg[ppoc_pkg::CFG_PANEL_EN];

////////////////////////////////////////////////////////////////////////////////
always_comb begin
    st_d = st_q;
    // reverse applies to any panel type; graphics escapes when text-only is set
    reverse_on = st_q.opt_a[ppoc_pkg::OPT_A_REV_EN] &&
        !(st_q.pol_sync[ppoc_pkg::POL_TEXT_ONLY] && attr_graphics_mode);
    // bus slave: one wait state, ack drops the cycle after it is given
    st_d.ack = wb_req;
    st_d.rdata = 32'h0000_0000;
    if (wb_req && wb_we_i) begin
        case (wb_adr_i)
            6'(ppoc_pkg::ADDR_OPT_A): st_d.opt_a = ppoc_merge(st_q.opt_a, wb_dat_i, wb_sel_i[0]);
            6'(ppoc_pkg::ADDR_POL_SYNC): st_d.pol_sync =
                ppoc_merge(st_q.pol_sync, wb_dat_i, wb_sel_i[0]);
            6'(ppoc_pkg::ADDR_SYNC_DLY): st_d.sync_dly =
                ppoc_merge(st_q.sync_dly, wb_dat_i, wb_sel_i[0]);
            6'(ppoc_pkg::ADDR_PANEL_TYPE): st_d.panel_type =
                ppoc_merge(st_q.panel_type, wb_dat_i, wb_sel_i[0]);
            6'(ppoc_pkg::ADDR_CFG): st_d.cfg = ppoc_merge(st_q.cfg, wb_dat_i, wb_sel_i[0]);
            default: begin
            end
        endcase
    end
    if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
            6'(ppoc_pkg::ADDR_OPT_A): st_d.rdata = {24'h000000, st_q.opt_a};
            6'(ppoc_pkg::ADDR_POL_SYNC): st_d.rdata = {24'h000000, st_q.pol_sync};
            6'(ppoc_pkg::ADDR_SYNC_DLY): st_d.rdata = {24'h000000, st_q.sync_dly};
            6'(ppoc_pkg::ADDR_PANEL_TYPE): st_d.rdata = {24'h000000, st_q.panel_type};
            6'(ppoc_pkg::ADDR_CFG): st_d.rdata = {24'h000000, st_q.cfg};
            6'(ppoc_pkg::ADDR_STATUS): st_d.rdata = {24'h000000, st_q.hs, st_q.vs,
                st_q.sim, st_q.psel, st_q.dith, reverse_on, st_q.lbd, st_q.hbd};
            default: st_d.rdata = 32'h0000_0000;
        endcase
    end

    // hsync delay line: tap 0 is the undelayed sync
    st_d.hs_line = {st_q.hs_line[6:0], crt_hsync_raw};
    hs_delayed = (hs_delay == 3'h0) ? crt_hsync_raw : st_q.hs_line[hs_delay - 3'h1];

    // tft forces active low syncs; otherwise misc output bit set means negative sync
    if (tft_on) begin
        st_d.vs = ~crt_vsync_raw;
        st_d.hs = ~hs_delayed;
    end else begin
        st_d.vs = crt_vsync_raw ^ misc_output[ppoc_pkg::MISC_VSYNC_POL];
        st_d.hs = hs_delayed ^ misc_output[ppoc_pkg::MISC_HSYNC_POL];
    end

    if (st_q.pol_sync[ppoc_pkg::POL_SYNC_STEER]) begin
        st_d.lbd = st_d.vs;
        st_d.hbd = st_d.hs;
    end else begin
        st_d.lbd = low_byte_dir_int;
        st_d.hbd = high_byte_dir_int;
    end

    st_d.fp = frame_pulse_int ^ st_q.pol_sync[ppoc_pkg::POL_FRAME_INV];
    st_d.lp = line_pulse_int ^ st_q.pol_sync[ppoc_pkg::POL_LINE_INV];

    if (st_q.cfg[ppoc_pkg::CFG_PWRDN]) begin
        st_d.ud = 4'h0;
        st_d.ld = 4'h0;
    end else if (reverse_on && pix_invert_src) begin
        st_d.ud = ~upper_panel_data_int;
        st_d.ld = ~lower_panel_data_int;
    end else begin
        st_d.ud = upper_panel_data_int;
        st_d.ld = lower_panel_data_int;
    end

    st_d.psel = crt_only;
    // gating the dither clock saves power when the panel needs no dither
    st_d.dith = st_q.cfg[ppoc_pkg::CFG_DITHER] && st_q.cfg[ppoc_pkg::CFG_PANEL_EN] &&
        !st_q.cfg[ppoc_pkg::CFG_PWRDN];
    st_d.dac = st_q.opt_a[ppoc_pkg::OPT_A_DAC_OFF];
    st_d.c4k = st_q.cfg[ppoc_pkg::CFG_STN_COLOR];
    st_d.sim = sim_mode && st_q.cfg[ppoc_pkg::CFG_VEXP] && st_q.cfg[ppoc_pkg::CFG_CENTER];
end

////////////////////////////////////////////////////////////////////////////////
always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        st_q <= '0;
        st_q.opt_a <= ppoc_pkg::RST_OPT_A;
        st_q.pol_sync <= ppoc_pkg::RST_POL_SYNC;
        st_q.sync_dly <= ppoc_pkg::RST_SYNC_DLY;
        st_q.panel_type <= ppoc_pkg::RST_PANEL_TYPE;
        st_q.cfg <= ppoc_pkg::RST_CFG;
    end else if (clk_en) begin
        st_q <= st_d;
    end
end

assign wb_dat_o = st_q.rdata;
assign wb_ack_o = st_q.ack;
assign low_byte_dir = st_q.lbd;
assign high_byte_dir = st_q.hbd;
assign crt_vsync = st_q.vs;
assign crt_hsync = st_q.hs;
assign frame_pulse = st_q.fp;
assign line_pulse = st_q.lp;
assign upper_panel_data = st_q.ud;
assign lower_panel_data = st_q.ld;
assign panel_select_out = st_q.psel;
assign dither_clk_en = st_q.dith;
assign dac_off = st_q.dac;
assign color_depth_4k = st_q.c4k;
assign simul_expand_center = st_q.sim;

endmodule : ppoc_panel_output_option_control
`default_nettype wire

// ### testbench/ppoc_props.sv
`timescale 1ns/10ps
`default_nettype none
module ppoc_props (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic frame_pulse_int,
    input wire logic line_pulse_int,
    input wire logic low_byte_dir,
    input wire logic high_byte_dir,
    input wire logic crt_vsync,
    input wire logic crt_hsync,
    input wire logic frame_pulse,
    input wire logic line_pulse,
    input wire logic [3:0] upper_panel_data,
    input wire logic [3:0] lower_panel_data,
    input wire logic panel_select_out
);
    logic [7:0] pol_q;
    logic [7:0] cfg_q;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // shadows follow the take edge, so $past of them is what the outputs were built from
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pol_q <= 8'h00;
            cfg_q <= 8'h01;
        end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]) begin
            if (wb_adr_i == 6'h04) pol_q <= wb_dat_i[7:0];
            if (wb_adr_i == 6'h10) cfg_q <= wb_dat_i[7:0];
        end
    end
    bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("dat_o not 0");
    steer_sync_a: assert property ($past(pol_q[2]) |->
        low_byte_dir == crt_vsync && high_byte_dir == crt_hsync) else $error("steer wrong");
    frame_pol_a: assert property (frame_pulse == ($past(frame_pulse_int) ^ $past(pol_q[1])))
        else $error("frame pulse polarity");
    line_pol_a: assert property (line_pulse == ($past(line_pulse_int) ^ $past(pol_q[0])))
        else $error("line pulse polarity");
    panel_sel_a: assert property (panel_select_out == ($past(cfg_q[1]) && !$past(cfg_q[0])))
        else $error("panel select level");
    pwrdn_low_a: assert property ($past(cfg_q[2]) |-> upper_panel_data == 4'h0
        && lower_panel_data == 4'h0) else $error("panel data not low");
endmodule : ppoc_props
bind ppoc_panel_output_option_control ppoc_props ppoc_props_i (.*);
`default_nettype wire

// ### testbench/ppoc_crt_model.sv
`timescale 1ns/10ps
`default_nettype none
module ppoc_crt_model (
    input wire logic core_clk,
    input wire logic crt_hsync,
    output logic [7:0] hs_cnt
);
    logic hs_q = 1'b0;
    initial hs_cnt = 8'h00;
    // a monitor only locks to sync edges, so it counts rises
    always @(posedge core_clk) begin
        if (crt_hsync && !hs_q) hs_cnt <= hs_cnt + 8'h01;
        hs_q <= crt_hsync;
    end
endmodule : ppoc_crt_model
`default_nettype wire

// ### testbench/ppoc_panel_output_option_control_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module ppoc_panel_output_option_control_tb_top;
    logic core_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0, wb_ack_o, attr_graphics_mode, crt_vsync_raw, crt_hsync_raw;
    logic [5:0] wb_adr_i = 6'h00;
    logic [3:0] wb_sel_i = 4'h0, upper_panel_data_int, lower_panel_data_int, ud, ld;
    logic [3:0] upper_panel_data, lower_panel_data;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, seed = 32'h33, q[$];
    logic low_byte_dir_int, high_byte_dir_int, frame_pulse_int, line_pulse_int;
    logic pix_invert_src, low_byte_dir, high_byte_dir, crt_vsync, crt_hsync, frame_pulse;
    logic line_pulse, panel_select_out, dither_clk_en, dac_off, color_depth_4k;
    logic simul_expand_center, look = 1'b0, dmode = 1'b0, hs_q = 1'b0, vs, hs, rv;
    logic [15:0] v = 16'h0;
    logic [7:0] misc_output = 8'h00, hs_cnt, age = 8'h00, o, p, t, c, h0;
    int err_total = 0, checks_done = 0, cyc_n = 0;
    assign {attr_graphics_mode, crt_vsync_raw, crt_hsync_raw, low_byte_dir_int,
        high_byte_dir_int, frame_pulse_int, line_pulse_int, upper_panel_data_int,
        lower_panel_data_int, pix_invert_src} = v;
    ppoc_panel_output_option_control ppoc_panel_output_option_control_i (.*);
    ppoc_crt_model ppoc_crt_model_i (.*);
    always #12.5 core_clk = ~core_clk;
    ////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    task automatic results();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : results
    task automatic cmp(input string n, input logic [31:0] got);
        logic [31:0] e;
        e = q.pop_front();
        checks_done++;
        if (got !== e) begin
            err_total++;
            $display("[ERR] %s exp %h got %h", n, e, got);
        end
    endtask : cmp
    task automatic bus(input logic [5:0] a, input logic w, input logic [7:0] d);
        @(posedge core_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i} <= {2'b11, w, a};
        wb_sel_i <= 4'h1;
        wb_dat_i <= {24'h0, d};
        do @(posedge core_clk); while (wb_ack_o !== 1'b1);
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask : bus
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        q.push_back({24'h0, e});
        bus(a, 1'b0, 8'h00);
    endtask : rd
    ////////////////////////////////////////
    // results come off the queue in the order the driver expected them
    always @(posedge core_clk) begin
        hs_q <= crt_hsync;
        age <= crt_hsync_raw ? age + 8'h01 : 8'h00;
        if (wb_ack_o && !wb_we_i) cmp("wb_dat_o", wb_dat_o);
        if (look) cmp("pins", {13'h0, dither_clk_en, dac_off, color_depth_4k,
            simul_expand_center, low_byte_dir, high_byte_dir, crt_vsync, crt_hsync,
            frame_pulse, line_pulse, upper_panel_data, lower_panel_data, panel_select_out});
        if (dmode && crt_hsync && !hs_q) cmp("hs_delay", {24'h0, age});
        if (++cyc_n > 6000) begin
            err_total++;
            results();
        end
    end
    initial begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(6'h04, 8'h00);
        rd(6'h10, 8'h01);
        rd(6'h18, 8'h00);
        rd(6'h14, 8'h00);
        for (int i = 0; i < 40; i++) begin
            seed = xs(seed);
            {o, p, t, c} = seed;
            bus(6'h00, 1'b1, o);
            bus(6'h04, 1'b1, p);
            bus(6'h0c, 1'b1, t);
            bus(6'h10, 1'b1, c);
            rd(6'h04, p);
            seed = xs(seed);
            {misc_output, v} <= seed[23:0];
            repeat (9) @(posedge core_clk);
            vs = t[3] ? !v[14] : v[14] ^ misc_output[7];
            hs = t[3] ? !v[13] : v[13] ^ misc_output[6];
            rv = o[4] && (!p[3] || !v[15]) && v[0];
            ud = c[2] ? 4'h0 : v[8:5] ^ {4{rv}};
            ld = c[2] ? 4'h0 : v[4:1] ^ {4{rv}};
            q.push_back({13'h0, c[3] && c[0] && !c[2], o[7], c[4],
                c[1] && c[0] && c[5] && c[6],
                p[2] ? vs : v[12], p[2] ? hs : v[11], vs, hs,
                v[10] ^ p[1], v[9] ^ p[0], ud, ld, c[1] && !c[0]});
            look <= 1'b1;
            @(posedge core_clk);
            look <= 1'b0;
        end
        // plain syncs so only the delay line moves the hsync edge
        {misc_output, v} <= 24'h0;
        bus(6'h0c, 1'b1, 8'h00);
        repeat (12) @(posedge core_clk);
        h0 = hs_cnt;
        dmode <= 1'b1;
        for (int n = 0; n < 8; n++) begin
            bus(6'h08, 1'b1, {n[2], 5'h00, n[1:0]});
            q.push_back(32'(n + 1));
            v[13] <= 1'b1;
            repeat (12) @(posedge core_clk);
            v[13] <= 1'b0;
            repeat (12) @(posedge core_clk);
        end
        q.push_back(32'h0000_0008);
        cmp("hs_cnt", {24'h0, hs_cnt - h0});
        results();
    end
endmodule : ppoc_panel_output_option_control_tb_top
`default_nettype wire
